/* File: power_mode_sequencer_defs.vh */
// Constants for the power mode sequencer: states, timings and field codes.
`ifndef POWER_MODE_SEQUENCER_DEFS_VH
`define POWER_MODE_SEQUENCER_DEFS_VH

`define PMS_CLK_MHZ           250
`define PMS_WAKE_WINDOW_US    9000
`define PMS_WAKE_WINDOW_CYC   (`PMS_WAKE_WINDOW_US * `PMS_CLK_MHZ)
`define PMS_SOFT_RAMP_US      1024
`define PMS_SOFT_STEPS        16
`define PMS_SOFT_STEP_CYC     ((`PMS_SOFT_RAMP_US * `PMS_CLK_MHZ) / `PMS_SOFT_STEPS)
`define PMS_SOFT_START_PCT    40
`define PMS_WAKE_FILT_CYC     16

`define PMS_ST_POWER_OFF      4'h0
`define PMS_ST_WAKE_MON       4'h1
`define PMS_ST_AWAKE          4'h2
`define PMS_ST_STARTUP        4'h3
`define PMS_ST_RUN            4'h4
`define PMS_ST_SHUTDOWN       4'h5
`define PMS_ST_RESERVE        4'h6
`define PMS_ST_BLANKING       4'h7

`define PMS_BOOST_V_LOW       1'b0
`define PMS_BOOST_V_HIGH      1'b1
`define PMS_SYNC_V_DEFAULT    1'b0

`endif

/* File: input_filter.v */
// Three-flop synchroniser with an agreement counter that filters glitches.
`default_nettype none

module input_filter #(
  parameter integer FILT_CYC = 16,
  parameter integer CW       = 5
) (
  input  wire clk,
  input  wire srst,
  input  wire rawIn,
  output reg  filtOut
);

  reg          sync1_r;
  reg          sync2_r;
  reg          sync3_r;
  reg [CW-1:0] cnt_r;

  // The first flop is read only by the second; agreement of the
  // second and third flops starts the stability count.
  always @(posedge clk) begin
    if (srst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      cnt_r   <= {CW{1'b0}};
      filtOut <= 1'b0;
    end else begin
      sync1_r <= rawIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r != sync3_r || sync3_r == filtOut) begin
        cnt_r <= {CW{1'b0}};
      end else if (cnt_r == FILT_CYC[CW-1:0]) begin
        filtOut <= sync3_r;
        cnt_r   <= {CW{1'b0}};
      end else begin
        cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // input_filter

`default_nettype wire

/* File: power_mode_sequencer.v */
// Power mode sequencer with reserve boost regulator control.
`include "power_mode_sequencer_defs.vh"
`default_nettype none

module power_mode_sequencer #(
  parameter integer WAKE_WINDOW_CYC = `PMS_WAKE_WINDOW_CYC,
  parameter integer SOFT_STEP_CYC   = `PMS_SOFT_STEP_CYC,
  parameter integer WAKE_FILT_CYC   = `PMS_WAKE_FILT_CYC
) (
  input  wire       clk,
  input  wire       srst,
  input  wire       wakeAboveMon,
  input  wire       inputRailAboveMin,
  input  wire       inputRailLow,
  input  wire       inputRailGood,
  input  wire       syncBoostGood,
  input  wire       satBuckGood,
  input  wire       logicBuckGood,
  input  wire       boostOverVolt,
  input  wire       boostUnderVolt,
  input  wire       boostOverTemp,
  input  wire       boostGroundLost,
  input  wire       sleepCmd,
  input  wire       satBuckOffCmd,
  input  wire       chargeEnCmd,
  input  wire       chargeDisCmd,
  input  wire       dischargeEnCmd,
  input  wire       dischargeDisCmd,
  input  wire       boostEnCtl,
  input  wire       boostHighVoltSel,
  input  wire       keepReserveBoostBit,
  input  wire       faultStatusRead,
  output reg        wakeDetectEn,
  output reg        internalRegEn,
  output reg        syncBoostEn,
  output reg        syncBoostVoltSel,
  output reg        satBuckEn,
  output reg        logicBuckEn,
  output reg        resetOutN,
  output reg        reserveBoostEn,
  output reg        boostGateEn,
  output reg        boostVoltSel,
  output reg  [3:0] boostLimitStep,
  output reg        chargeCurrentEn,
  output reg        dischargeCurrentEn,
  output reg        reserveSwitchEn,
  output reg        crossoverActiveOut,
  output reg  [3:0] powerState,
  output reg  [2:0] faultStatus
);

  ////////////////////////////////////////////////////////////////////////
  // Input filtering and synchronisation.

  wire wakeFilt;
  reg  [2:0] rlSync_r;
  reg  [2:0] rgSync_r;
  reg  [2:0] amSync_r;
  reg  [2:0] gndSync_r;
  reg        railLow_r;
  reg        railGood_r;
  reg        railMin_r;
  reg        gndLost_r;

  input_filter #(
    .FILT_CYC (WAKE_FILT_CYC),
    .CW       (8)
  ) u_wake_filter (
    .clk     (clk),
    .srst    (srst),
    .rawIn   (wakeAboveMon),
    .filtOut (wakeFilt)
  );

  // Comparator pins pass three flops; a change counts once two agree.
  always @(posedge clk) begin
    if (srst) begin
      rlSync_r   <= 3'h0;
      rgSync_r   <= 3'h0;
      amSync_r   <= 3'h0;
      gndSync_r  <= 3'h0;
      railLow_r  <= 1'b0;
      railGood_r <= 1'b0;
      railMin_r  <= 1'b0;
      gndLost_r  <= 1'b0;
    end else begin
      rlSync_r  <= {rlSync_r[1:0], inputRailLow};
      rgSync_r  <= {rgSync_r[1:0], inputRailGood};
      amSync_r  <= {amSync_r[1:0], inputRailAboveMin};
      gndSync_r <= {gndSync_r[1:0], boostGroundLost};
      if (rlSync_r[1] == rlSync_r[2]) railLow_r <= rlSync_r[2];
      if (rgSync_r[1] == rgSync_r[2]) railGood_r <= rgSync_r[2];
      if (amSync_r[1] == amSync_r[2]) railMin_r <= amSync_r[2];
      if (gndSync_r[1] == gndSync_r[2]) gndLost_r <= gndSync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power mode state machine.

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [23:0] winCnt_r;
  wire       winOpen = (winCnt_r != WAKE_WINDOW_CYC[23:0]);
  reg        sleepPend_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PMS_ST_POWER_OFF: begin
        if (wakeFilt) state_nxt = `PMS_ST_WAKE_MON;
      end
      `PMS_ST_WAKE_MON: begin
        if (!wakeFilt) state_nxt = `PMS_ST_POWER_OFF;
        else state_nxt = `PMS_ST_AWAKE;
      end
      `PMS_ST_AWAKE: begin
        if (!wakeFilt) state_nxt = `PMS_ST_WAKE_MON;
        else if (railMin_r) state_nxt = `PMS_ST_STARTUP;
      end
      `PMS_ST_STARTUP, `PMS_ST_RUN: begin
        if (railLow_r || !railGood_r && state_r == `PMS_ST_RUN &&
            !railLow_r) begin
          state_nxt = `PMS_ST_RESERVE;
        end else if (!wakeFilt && winOpen) begin
          state_nxt = `PMS_ST_AWAKE;
        end else if (!wakeFilt && sleepPend_r) begin
          state_nxt = `PMS_ST_SHUTDOWN;
        end else if (!winOpen) begin
          state_nxt = `PMS_ST_RUN;
        end
      end
      `PMS_ST_SHUTDOWN: begin
        if (satBuckOffCmd) state_nxt = `PMS_ST_POWER_OFF;
      end
      `PMS_ST_RESERVE: begin
        // Leaving reserve only happens via internal power-on reset.
        state_nxt = `PMS_ST_RESERVE;
      end
      default: state_nxt = `PMS_ST_POWER_OFF;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_r     <= `PMS_ST_POWER_OFF;
      winCnt_r    <= 24'h0000_00;
      sleepPend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != `PMS_ST_STARTUP && state_r != `PMS_ST_RUN) begin
        winCnt_r <= 24'h0000_00;
      end else if (winOpen) begin
        winCnt_r <= winCnt_r + 24'h0000_01;
      end
      // Sleep command counts only after the window; earlier it is ignored.
      if (state_r != `PMS_ST_RUN) sleepPend_r <= 1'b0;
      else if (sleepCmd && !winOpen) sleepPend_r <= 1'b1;
    end
  end

  wire isActive  = (state_r == `PMS_ST_STARTUP) || (state_r == `PMS_ST_RUN);
  wire isPassive = (state_r == `PMS_ST_SHUTDOWN) ||
                   (state_r == `PMS_ST_RESERVE) ||
                   (state_r == `PMS_ST_BLANKING);
  wire isOn      = isActive || isPassive;

  ////////////////////////////////////////////////////////////////////////
  // Supply chain, reset and function permissions.

  reg chargeReq_r;
  reg dischargeReq_r;

  always @(posedge clk) begin
    if (srst) begin
      wakeDetectEn       <= 1'b0;
      internalRegEn      <= 1'b0;
      syncBoostEn        <= 1'b0;
      syncBoostVoltSel   <= `PMS_SYNC_V_DEFAULT;
      satBuckEn          <= 1'b0;
      logicBuckEn        <= 1'b0;
      resetOutN          <= 1'b0;
      chargeReq_r        <= 1'b0;
      dischargeReq_r     <= 1'b0;
      chargeCurrentEn    <= 1'b0;
      dischargeCurrentEn <= 1'b0;
      reserveSwitchEn    <= 1'b0;
      crossoverActiveOut <= 1'b0;
      powerState         <= `PMS_ST_POWER_OFF;
    end else begin
      wakeDetectEn     <= (state_r != `PMS_ST_POWER_OFF);
      internalRegEn    <= (state_r != `PMS_ST_POWER_OFF) &&
                          (state_r != `PMS_ST_WAKE_MON);
      syncBoostEn      <= isOn;
      syncBoostVoltSel <= `PMS_SYNC_V_DEFAULT;
      satBuckEn        <= isOn && (satBuckEn || syncBoostGood);
      logicBuckEn      <= isOn && (logicBuckEn || satBuckGood);
      resetOutN        <= isOn && logicBuckEn && logicBuckGood;
      // Charge requests wait for reset release; charge commands before then are void.
      if (!isActive || !resetOutN || chargeDisCmd) begin
        chargeReq_r <= 1'b0;
      end else if (chargeEnCmd) begin
        chargeReq_r <= 1'b1;
      end
      if (!isOn || dischargeDisCmd) dischargeReq_r <= 1'b0;
      else if (dischargeEnCmd) dischargeReq_r <= 1'b1;
      // Charge and discharge stay mutually exclusive; charge wins.
      chargeCurrentEn    <= isActive && chargeReq_r;
      dischargeCurrentEn <= (isActive || state_r == `PMS_ST_SHUTDOWN) &&
                            dischargeReq_r && !chargeReq_r;
      reserveSwitchEn    <= isPassive;
      crossoverActiveOut <= (state_r == `PMS_ST_SHUTDOWN) ||
                            (state_r == `PMS_ST_RESERVE);
      powerState         <= state_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reserve boost regulator control.

  reg        otLatch_r;
  reg        boostOn_r;
  reg [3:0]  stepIdx_r;
  reg [17:0] stepCnt_r;
  wire       boostAllowed = isActive ||
                            (state_r == `PMS_ST_RESERVE &&
                             keepReserveBoostBit);

  always @(posedge clk) begin
    if (srst) begin
      otLatch_r      <= 1'b0;
      boostOn_r      <= 1'b0;
      stepIdx_r      <= 4'h0;
      stepCnt_r      <= 18'h0_0000;
      reserveBoostEn <= 1'b0;
      boostGateEn    <= 1'b0;
      boostVoltSel   <= `PMS_BOOST_V_LOW;
      boostLimitStep <= 4'h0;
      faultStatus    <= 3'h0;
    end else begin
      boostOn_r      <= boostAllowed && boostEnCtl;
      reserveBoostEn <= boostOn_r;
      boostVoltSel   <= boostHighVoltSel ? `PMS_BOOST_V_HIGH
                                         : `PMS_BOOST_V_LOW;
      // Restart the ramp on every off-to-on transition.
      if (!boostOn_r) begin
        stepIdx_r <= 4'h0;
        stepCnt_r <= 18'h0_0000;
      end else if (stepIdx_r != 4'hF) begin
        if (stepCnt_r == SOFT_STEP_CYC[17:0] - 18'h0_0001) begin
          stepCnt_r <= 18'h0_0000;
          stepIdx_r <= stepIdx_r + 4'h1;
        end else begin
          stepCnt_r <= stepCnt_r + 18'h0_0001;
        end
      end
      boostLimitStep <= stepIdx_r;
      // A new fault in the read cycle wins over the clear.
      if (boostOverTemp) otLatch_r <= 1'b1;
      else if (faultStatusRead) otLatch_r <= 1'b0;
      boostGateEn <= boostOn_r && !boostOverVolt && !boostOverTemp &&
                     !otLatch_r && !gndLost_r;
      faultStatus <= {otLatch_r || boostOverTemp, boostUnderVolt,
                      boostOverVolt};
    end
  end

endmodule // power_mode_sequencer

`default_nettype wire

/* File: power_mode_sequencer_asserts.sv */
// Concurrent checks on the power mode sequencer ports.
`default_nettype none

module power_mode_sequencer_asserts (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [3:0] powerState,
  input wire logic       resetOutN,
  input wire logic       syncBoostGood,
  input wire logic       satBuckGood,
  input wire logic       logicBuckGood,
  input wire logic       syncBoostEn,
  input wire logic       satBuckEn,
  input wire logic       logicBuckEn,
  input wire logic       internalRegEn,
  input wire logic       reserveSwitchEn,
  input wire logic       crossoverActiveOut,
  input wire logic       chargeCurrentEn,
  input wire logic       boostOverVolt,
  input wire logic       boostUnderVolt,
  input wire logic       boostOverTemp,
  input wire logic       boostGroundLost,
  input wire logic       satBuckOffCmd,
  input wire logic       boostGateEn,
  input wire logic [2:0] faultStatus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_buck_after_sync: assert property ($rose(satBuckEn) |->
    $past(syncBoostGood)) else $error("buck before sync boost good");
  a_logic_after_sat: assert property ($rose(logicBuckEn) |->
    $past(satBuckGood)) else $error("logic buck before sat buck good");
  a_reset_release: assert property ($rose(resetOutN) |->
    $past(logicBuckGood)) else $error("reset released too early");
  a_off_quiet: assert property (powerState == 4'h0 &&
    $past(powerState) == 4'h0 |-> !syncBoostEn && !satBuckEn &&
    !logicBuckEn && !internalRegEn) else $error("supply on in off");
  a_passive_outs: assert property (powerState inside {4'h5, 4'h6} &&
    $past(powerState) == powerState |-> reserveSwitchEn &&
    crossoverActiveOut && !chargeCurrentEn) else $error("passive outs");
  a_ov_gate: assert property (boostOverVolt |=>
    !boostGateEn && faultStatus[0]) else $error("over-voltage kept gate");
  a_uv_flag: assert property (boostUnderVolt |=>
    faultStatus[1]) else $error("under-voltage not flagged");
  a_ot_gate: assert property (boostOverTemp |=>
    !boostGateEn && faultStatus[2]) else $error("thermal kept gate");
  a_gnd_block: assert property (boostGroundLost[*6] |->
    !boostGateEn) else $error("gate on with ground lost");
  a_shut_off: assert property (powerState == 4'h5 && satBuckOffCmd |->
    ##[1:3] powerState == 4'h0) else $error("shutdown did not end");
endmodule // power_mode_sequencer_asserts

bind power_mode_sequencer power_mode_sequencer_asserts chk_u (.*);

`default_nettype wire

/* File: supply_responder.sv */
// Model of the external regulators reporting their output good levels.
`default_nettype none

module supply_responder (
  input wire logic clk,
  input wire logic syncBoostEn,
  input wire logic satBuckEn,
  input wire logic logicBuckEn,
  output var logic syncBoostGood = 1'b0,
  output var logic satBuckGood   = 1'b0,
  output var logic logicBuckGood = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] syncDly = 3'h0;
  logic [2:0] satDly  = 3'h0;
  logic [2:0] logDly  = 3'h0;

  // Rails take a few cycles to ramp but collapse at once when disabled.
  always @(posedge clk) begin
    syncDly <= syncBoostEn ? {syncDly[1:0], 1'b1} : 3'h0;
    satDly <= satBuckEn ? {satDly[1:0], 1'b1} : 3'h0;
    logDly <= logicBuckEn ? {logDly[1:0], 1'b1} : 3'h0;
    syncBoostGood <= #1 syncDly[2];
    satBuckGood <= #1 satDly[2];
    logicBuckGood <= #1 logDly[2];
  end
endmodule // supply_responder

`default_nettype wire

/* File: power_mode_sequencer_test.sv */
// Directed testbench for the power mode sequencer.
`default_nettype none

module power_mode_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, wakeAboveMon = 1'b0;
  logic inputRailAboveMin = 1'b0, inputRailLow = 1'b0, inputRailGood = 1'b1;
  logic boostOverVolt = 1'b0, boostUnderVolt = 1'b0, boostOverTemp = 1'b0;
  logic boostGroundLost = 1'b0, sleepCmd = 1'b0, satBuckOffCmd = 1'b0;
  logic chargeEnCmd = 1'b0, chargeDisCmd = 1'b0, dischargeEnCmd = 1'b0;
  logic dischargeDisCmd = 1'b0, boostEnCtl = 1'b1, boostHighVoltSel = 1'b0;
  logic keepReserveBoostBit = 1'b0, faultStatusRead = 1'b0;
  logic syncBoostGood, satBuckGood, logicBuckGood, wakeDetectEn;
  logic internalRegEn, syncBoostEn, syncBoostVoltSel, satBuckEn;
  logic logicBuckEn, resetOutN, reserveBoostEn, boostGateEn, boostVoltSel;
  logic chargeCurrentEn, dischargeCurrentEn, reserveSwitchEn;
  logic crossoverActiveOut;
  logic [3:0] boostLimitStep, powerState;
  logic [2:0] faultStatus;
  int n_fail = 0;
  int cmp_count = 0;

  power_mode_sequencer #(.WAKE_WINDOW_CYC(200), .SOFT_STEP_CYC(4),
    .WAKE_FILT_CYC(4)) dut_u (.*);
  supply_responder supply_u (.*);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [3:0] ex,
                     input logic [3:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic waitSt(input logic [3:0] s);
    int i;
    for (i = 0; i < 400 && powerState !== s; i++) tick(1);
    chk("powerState", s, powerState);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    n_fail++;
    results();
  end

  initial begin
    tick(16);
    srst = 1'b0;
    wakeAboveMon = 1'b1;
    inputRailAboveMin = 1'b1;
    waitSt(4'h3);
    pulse(chargeEnCmd);
    for (int i = 0; i < 60 && resetOutN !== 1'b1; i++) tick(1);
    chk("resetOutN", 4'h1, {3'h0, resetOutN});
    chk("chargeCurrentEn", 4'h0, {3'h0, chargeCurrentEn});
    chk("wakeDetectEn", 4'h1, {3'h0, wakeDetectEn});
    chk("syncBoostVoltSel", 4'h0, {3'h0, syncBoostVoltSel});
    chk("boostVoltSel", 4'h0, {3'h0, boostVoltSel});
    chk("internalRegEn", 4'h1, {3'h0, internalRegEn});
    wakeAboveMon = 1'b0;
    tick(1);
    wakeAboveMon = 1'b1;
    tick(20);
    chk("powerState", 4'h3, powerState);
    wakeAboveMon = 1'b0;
    waitSt(4'h2);
    wakeAboveMon = 1'b1;
    waitSt(4'h3);
    pulse(sleepCmd);
    waitSt(4'h4);
    $display("power-up test done");
    pulse(chargeEnCmd);
    tick(2);
    chk("chargeCurrentEn", 4'h1, {3'h0, chargeCurrentEn});
    pulse(dischargeEnCmd);
    tick(2);
    chk("dischargeCurrentEn", 4'h0, {3'h0, dischargeCurrentEn});
    pulse(chargeDisCmd);
    tick(2);
    chk("chargeCurrentEn", 4'h0, {3'h0, chargeCurrentEn});
    chk("dischargeCurrentEn", 4'h1, {3'h0, dischargeCurrentEn});
    boostHighVoltSel = 1'b1;
    tick(2);
    chk("boostVoltSel", 4'h1, {3'h0, boostVoltSel});
    chk("boostGateEn", 4'h1, {3'h0, boostGateEn});
    boostOverVolt = 1'b1;
    tick(1);
    chk("boostGateEn", 4'h0, {3'h0, boostGateEn});
    chk("faultStatus", 4'h1, {3'h0, faultStatus[0]});
    boostOverVolt = 1'b0;
    boostUnderVolt = 1'b1;
    tick(1);
    chk("faultStatus", 4'h1, {3'h0, faultStatus[1]});
    boostUnderVolt = 1'b0;
    boostOverTemp = 1'b1;
    tick(2);
    boostOverTemp = 1'b0;
    tick(6);
    chk("boostGateEn", 4'h0, {3'h0, boostGateEn});
    chk("faultStatus", 4'h1, {3'h0, faultStatus[2]});
    pulse(faultStatusRead);
    tick(3);
    chk("boostGateEn", 4'h1, {3'h0, boostGateEn});
    chk("faultStatus", 4'h0, {3'h0, faultStatus[2]});
    boostGroundLost = 1'b1;
    tick(8);
    chk("boostGateEn", 4'h0, {3'h0, boostGateEn});
    boostGroundLost = 1'b0;
    tick(8);
    chk("boostGateEn", 4'h1, {3'h0, boostGateEn});
    boostEnCtl = 1'b0;
    tick(3);
    boostEnCtl = 1'b1;
    tick(2);
    chk("boostLimitStep", 4'h0, boostLimitStep);
    tick(30);
    chk("boostLimitStep", 4'h7, boostLimitStep);
    tick(40);
    chk("boostLimitStep", 4'hf, boostLimitStep);
    $display("boost test done");
    wakeAboveMon = 1'b0;
    tick(20);
    chk("powerState", 4'h4, powerState);
    pulse(sleepCmd);
    waitSt(4'h5);
    tick(2);
    chk("reserveSwitchEn", 4'h1, {3'h0, reserveSwitchEn});
    chk("crossoverActiveOut", 4'h1, {3'h0, crossoverActiveOut});
    chk("chargeCurrentEn", 4'h0, {3'h0, chargeCurrentEn});
    chk("reserveBoostEn", 4'h0, {3'h0, reserveBoostEn});
    pulse(dischargeDisCmd);
    tick(2);
    chk("dischargeCurrentEn", 4'h0, {3'h0, dischargeCurrentEn});
    pulse(dischargeEnCmd);
    tick(2);
    chk("dischargeCurrentEn", 4'h1, {3'h0, dischargeCurrentEn});
    pulse(satBuckOffCmd);
    waitSt(4'h0);
    tick(2);
    chk("satBuckEn", 4'h0, {3'h0, satBuckEn});
    chk("wakeDetectEn", 4'h0, {3'h0, wakeDetectEn});
    $display("shutdown test done");
    keepReserveBoostBit = 1'b1;
    wakeAboveMon = 1'b1;
    waitSt(4'h3);
    waitSt(4'h4);
    inputRailLow = 1'b1;
    inputRailGood = 1'b0;
    waitSt(4'h6);
    tick(2);
    chk("reserveBoostEn", 4'h1, {3'h0, reserveBoostEn});
    chk("reserveSwitchEn", 4'h1, {3'h0, reserveSwitchEn});
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    chk("powerState", 4'h0, powerState);
    $display("reserve test done");
    results();
  end
endmodule // power_mode_sequencer_test

`default_nettype wire
